// ==== verilog/resu_defs.svh ====
// register offsets, field positions and reset values
`ifndef RESU_DEFS_SVH
`define RESU_DEFS_SVH
`define RESU_ADDR_W           8
`define RESU_OFS_FLAGS        8'h20
`define RESU_OFS_ENABLE       8'h21
`define RESU_OFS_MODE_HIGH    8'h22
`define RESU_OFS_MODE_LOW     8'h23
`define RESU_OFS_BUF_CTRL     8'h24
`define RESU_OFS_STREAM_INFO  8'h25
`define RESU_OFS_FAULTS       8'h26
`define RESU_SRC_MASK         8'hBB
`define RESU_BIT_LOCK_LOSS    7
`define RESU_BIT_NEW_SUBCODE  5
`define RESU_BIT_CS_XFER      4
`define RESU_BIT_USER_XFER    3
`define RESU_BIT_ADC_RANGE    1
`define RESU_BIT_RX_FAULT     0
`define RESU_BIT_SUBFRAME_SEL 0
`define RESU_BIT_ACCESS_WIDTH 1
`define RESU_BIT_WINDOW_SEL   2
`define RESU_BIT_LOCK_METHOD  6
`define RESU_ENABLE_RESET     8'h00
`define RESU_MODE_RESET       8'h00
`define RESU_BUF_CTRL_RESET   8'h40
`define RESU_AUX_MAX          4'h8
`endif

// ==== verilog/resu_pkg.sv ====
// types shared by the event status unit
package resu_pkg;
  typedef enum logic [1:0] {
    RESU_TRIG_RISE  = 2'b00,
    RESU_TRIG_FALL  = 2'b01,
    RESU_TRIG_LEVEL = 2'b10,
    RESU_TRIG_RSVD  = 2'b11
  } resu_trig_t;
  typedef enum logic [1:0] {
    RESU_PIN_HIGH  = 2'b00,
    RESU_PIN_LOW   = 2'b01,
    RESU_PIN_OPEN  = 2'b10,
    RESU_PIN_RSVD  = 2'b11
  } resu_pin_t;
endpackage

// ==== verilog/resu_event_status.sv ====
// receiver event status unit: flags, enables, trigger modes, status
`timescale 1ns/1ps
`include "resu_defs.svh"
module resu_event_status
  import resu_pkg::*;
(
  input  wire logic       clk_sys,           // 20 MHz device clock
  input  wire logic       resetn,            // synchronous reset, low
  input  wire logic [7:0] reg_addr,          // control port address
  input  wire logic       reg_wr,            // write strobe
  input  wire logic [7:0] reg_wdata,         // write data
  input  wire logic       reg_rd,            // read strobe
  output logic      [7:0] reg_rdata,         // read data, next cycle
  input  wire logic [1:0] pin_control,       // interrupt pin control
  input  wire logic       pll_unlocked,      // loop out of lock, level
  input  wire logic       subcode_changed,   // new subcode block differs
  input  wire logic       cs_buffer_xfer,    // cs buffer transferred
  input  wire logic       user_buffer_xfer,  // user buffer transferred
  input  wire logic       adc_overrange,     // adc over-range, level
  input  wire logic       subcode_boundary,  // subcode block boundary
  input  wire logic       subcode_crc_bad,   // subcode checksum fault
  input  wire logic       cs_block_boundary, // cs block boundary
  input  wire logic       cs_crc_bad,        // cs block checksum fault
  input  wire logic       subframe_boundary, // subframe boundary
  input  wire logic       subframe_b,        // boundary is subframe b
  input  wire logic       rx_validity,       // received validity bit
  input  wire logic       rx_biphase_bad,    // bi-phase violation
  input  wire logic       rx_parity_bad,     // parity error
  input  wire logic       rx_in_use,         // receiver in use
  input  wire logic [3:0] cs_aux_a,          // aux width, subframe a
  input  wire logic [3:0] cs_aux_b,          // aux width, subframe b
  input  wire logic [3:0] cs_bits_a,         // pro,audio,copy,original_generation_flag a
  input  wire logic [3:0] cs_bits_b,         // pro,audio,copy,original_generation_flag b
  input  wire logic       cs_general_a,      // category general, a
  input  wire logic       cs_general_b,      // category general, b
  output logic            int_out,           // interrupt pin level
  output logic            int_oe,            // interrupt pin enable
  output logic            buffer_window_select, // buffer window
  output logic            cs_access_width,   // cs access mode
  output logic            subframe_select,   // subframe shown
  output logic            receiver_lock_method // locking mode
);

  logic [7:0] event_flags;
  logic [7:0] event_enable_mask;
  logic [7:0] event_trigger_mode_high;
  logic [7:0] event_trigger_mode_low;
  logic [7:0] received_stream_info;
  logic [7:0] receive_fault_flags;
  logic [7:0] cond;
  logic [7:0] cond_q;
  logic [7:0] hit;
  logic [7:0] pin_hit;
  logic       pin_pending;
  logic       next_pin_pending;
  logic       flag_read;
  logic       fault_event;
  logic [7:0] stream_fields;
  resu_pin_t  pin_mode;

  // reset image of the buffer control register, sliced per field below
  localparam logic [7:0] buf_ctrl_rst = `RESU_BUF_CTRL_RESET;

  // how the pieces fit together
  //
  // event path, one lane per status bit position:
  //   cond        live level of each source, in status bit order
  //   cond_q      the same levels one cycle late, for edge detection
  //   hit         the lane's trigger code applied to cond and cond_q
  //   pin_hit     hit gated by the lane's enable bit
  //   event_flags sticky copy of pin_hit, cleared by a host read
  //
  // lanes 6 and 2 have no source; the source mask keeps them at zero
  // in the enable and both trigger mode registers and in the flags, so they read zero.
  //
  // a disabled lane never reaches the flags or the pin. the read
  // path also ands the flags with the enable mask, so that a flag
  // set before its lane was disabled is hidden from the host.
  //
  // a read of the flags returns the value held before the read edge.
  // a hit that lands on that same edge is kept for the next read:
  // the set has priority over the clear, so no event is lost.
  //
  // trigger code 11 is treated as never firing, so a lane left in
  // that code is silent rather than stuck active.
  //
  // edge lanes hold the pin active until the host reads the flags;
  // level lanes follow their condition and drop with it, read or not.
  //
  // the receiver fault source is the or of the fault register bits,
  // so it behaves as a level: a rising-edge lane flags a new fault
  // once and stays quiet while the same fault persists.
  //
  // the pin sense comes only from pin_control; the trigger codes
  // decide when the pin is active, never which level means active.
  //
  // every top-level output is a flip-flop, so the pin moves one
  // cycle after the event that causes it and never glitches.
  //
  // no register here is reset by a read other than the flags;
  // the fault and stream registers simply follow the receiver.

  // source conditions in status bit order
  always_comb begin
    cond = 8'h00;
    cond[`RESU_BIT_LOCK_LOSS]   = pll_unlocked;
    cond[`RESU_BIT_NEW_SUBCODE] = subcode_changed;
    cond[`RESU_BIT_CS_XFER]     = cs_buffer_xfer;
    cond[`RESU_BIT_USER_XFER]   = user_buffer_xfer;
    cond[`RESU_BIT_ADC_RANGE]   = adc_overrange;
    cond[`RESU_BIT_RX_FAULT]    = fault_event;
  end

  // any unmasked fault bit set counts as a receiver fault
  assign fault_event = |receive_fault_flags[6:0];

  // previous condition for edge detection
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cond_q <= 8'h00;
    end else begin
      cond_q <= cond;
    end
  end

  // per-source trigger decode
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_src
      resu_trig_t trig;
      // high bit from one register, low bit from the other
      assign trig = resu_trig_t'({event_trigger_mode_high[gi],
                                  event_trigger_mode_low[gi]});
      always_comb begin
        case (trig)
          RESU_TRIG_RISE:  hit[gi] = cond[gi] & ~cond_q[gi];
          RESU_TRIG_FALL:  hit[gi] = ~cond[gi] & cond_q[gi];
          RESU_TRIG_LEVEL: hit[gi] = cond[gi];
          default:         hit[gi] = 1'b0;
        endcase
      end
      assign pin_hit[gi] = hit[gi] & event_enable_mask[gi];
    end
  endgenerate

  assign flag_read = reg_rd && (reg_addr == `RESU_OFS_FLAGS);

  // sticky flags, clear on read
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      event_flags <= 8'h00;
    end else begin
      // clear on read, new events win over the clear
      event_flags <= ((flag_read ? 8'h00 : event_flags) | pin_hit)
                     & `RESU_SRC_MASK;
    end
  end

  // writable control registers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      event_enable_mask       <= `RESU_ENABLE_RESET;
      event_trigger_mode_high <= `RESU_MODE_RESET;
      event_trigger_mode_low  <= `RESU_MODE_RESET;
      // window and width reset to zero
      buffer_window_select    <= buf_ctrl_rst[`RESU_BIT_WINDOW_SEL];
      cs_access_width         <= buf_ctrl_rst[`RESU_BIT_ACCESS_WIDTH];
      subframe_select         <= buf_ctrl_rst[`RESU_BIT_SUBFRAME_SEL];
      receiver_lock_method    <= buf_ctrl_rst[`RESU_BIT_LOCK_METHOD];
    end else if (reg_wr) begin
      case (reg_addr)
        `RESU_OFS_ENABLE: event_enable_mask <= reg_wdata & `RESU_SRC_MASK;
        `RESU_OFS_MODE_HIGH: event_trigger_mode_high <= reg_wdata
                                                        & `RESU_SRC_MASK;
        `RESU_OFS_MODE_LOW: event_trigger_mode_low <= reg_wdata
                                                      & `RESU_SRC_MASK;
        `RESU_OFS_BUF_CTRL: begin
          buffer_window_select <= reg_wdata[`RESU_BIT_WINDOW_SEL];
          cs_access_width      <= reg_wdata[`RESU_BIT_ACCESS_WIDTH];
          subframe_select      <= reg_wdata[`RESU_BIT_SUBFRAME_SEL];
          receiver_lock_method <= reg_wdata[`RESU_BIT_LOCK_METHOD];
        end
        default: ;
      endcase
    end
  end

  // stream information notes
  //
  // the receiver hands over both subframes' decoded fields at once;
  // subframe_select picks which one the host sees.
  //
  // aux width codes above eight are reserved; they are shown as
  // received so the host can tell a reserved code from a real one.
  //
  // copy is forced high for the general category, and copy and
  // original are both forced high for professional data or when
  // the receiver is not in use.
  //
  // the register follows the selected subframe's boundary, and runs
  // freely while the receiver is unused so the forced bits show.

  // decode of the selected subframe's channel status
  always_comb begin
    logic [3:0] aux;
    logic [3:0] bits;
    logic       gen;
    aux  = subframe_select ? cs_aux_b : cs_aux_a;
    bits = subframe_select ? cs_bits_b : cs_bits_a;
    gen  = subframe_select ? cs_general_b : cs_general_a;
    // auxiliary width, reserved codes passed through
    stream_fields[7:4] = aux;
    stream_fields[3] = bits[3];
    stream_fields[2] = bits[2];
    stream_fields[1] = bits[1] | gen | bits[3] | ~rx_in_use;
    stream_fields[0] = bits[0] | bits[3] | ~rx_in_use;
  end

  // channel status register refreshed on subframe boundaries
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      received_stream_info <= 8'h00;
    end else if (!rx_in_use) begin
      received_stream_info <= stream_fields;
    end else if (subframe_boundary && (subframe_b == subframe_select)) begin
      received_stream_info <= stream_fields;
    end
  end

  // fault register notes
  //
  // bit 7 has no source and stays zero.
  // bits 6 and 5 follow their own block boundaries; between
  // boundaries they keep the last block's result.
  // bit 4 follows the loop lock state every cycle.
  // bits 3 to 0 follow the subframe boundary pulse.
  // the confidence bit is the or of the loop unlock and biphase inputs,
  // so it is set whenever the biphase bit beside it is set.
  //
  // a fault that is present feeds the receiver fault event lane.

  // receiver fault register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      receive_fault_flags <= 8'h00;
    end else begin
      if (subcode_boundary) begin
        receive_fault_flags[6] <= subcode_crc_bad;
      end
      if (cs_block_boundary) begin
        receive_fault_flags[5] <= cs_crc_bad;
      end
      receive_fault_flags[4] <= pll_unlocked;
      if (subframe_boundary) begin
        receive_fault_flags[3] <= rx_validity;
        receive_fault_flags[2] <= pll_unlocked | rx_biphase_bad;
        receive_fault_flags[1] <= rx_biphase_bad;
        receive_fault_flags[0] <= rx_parity_bad;
      end
    end
  end

  // read data mux, registered
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        // flags of disabled lanes are anded off, so they read zero
        `RESU_OFS_FLAGS:       reg_rdata <= event_flags & event_enable_mask;
        `RESU_OFS_ENABLE:      reg_rdata <= event_enable_mask;
        `RESU_OFS_MODE_HIGH:   reg_rdata <= event_trigger_mode_high;
        `RESU_OFS_MODE_LOW:    reg_rdata <= event_trigger_mode_low;
        `RESU_OFS_BUF_CTRL:    reg_rdata <= {1'b0, receiver_lock_method,
                                             3'b000, buffer_window_select,
                                             cs_access_width,
                                             subframe_select};
        `RESU_OFS_STREAM_INFO: reg_rdata <= received_stream_info;
        `RESU_OFS_FAULTS:      reg_rdata <= receive_fault_flags;
        default:               reg_rdata <= 8'h00;
      endcase
    end
  end

  // pin notes
  //
  // pending is the or of three terms:
  //   edge lanes whose flag is still set, unless read this cycle
  //   edge lanes that hit this cycle, which survive the read
  //   level lanes whose condition is present and enabled
  //
  // the pin flops are loaded from next_pin_pending, so the pin and
  // the flags change on the same edge.
  //
  // pin control 00 drives the pending state as is, 01 drives it
  // inverted, 10 drives low only while pending and otherwise lets
  // the pull-up hold the line, and 11 leaves the pin undriven.
  //
  // after reset the pin drives low with pin control at 00, which
  // is the inactive level for that setting.

  // pin pending: edge modes latch until the flags are read, level follows
  always_comb begin
    next_pin_pending = |(event_flags & event_enable_mask & ~flag_mask_lvl())
                       & ~flag_read;
    next_pin_pending = next_pin_pending
                       | |(pin_hit & ~flag_mask_lvl())
                       | |(cond & event_enable_mask & flag_mask_lvl());
  end

  function automatic logic [7:0] flag_mask_lvl();
    flag_mask_lvl = event_trigger_mode_high & ~event_trigger_mode_low;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pin_pending <= 1'b0;
    end else begin
      pin_pending <= next_pin_pending;
    end
  end

  assign pin_mode = resu_pin_t'(pin_control);

  // pin sense only from pin control
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      int_out <= 1'b0;
      int_oe  <= 1'b1;
    end else begin
      case (pin_mode)
        RESU_PIN_HIGH: begin
          int_out <= next_pin_pending;
          int_oe  <= 1'b1;
        end
        RESU_PIN_LOW: begin
          int_out <= ~next_pin_pending;
          int_oe  <= 1'b1;
        end
        RESU_PIN_OPEN: begin
          int_out <= 1'b0;
          int_oe  <= next_pin_pending;
        end
        default: begin
          int_out <= 1'b0;
          int_oe  <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ==== test/resu_event_status_monitor.sv ====
// port checker for the receiver event status unit
`timescale 1ns/1ps
module resu_event_status_monitor (
  input wire logic       clk_sys,              // device clock
  input wire logic       resetn,               // reset, low
  input wire logic [7:0] reg_addr,             // address
  input wire logic       reg_wr,               // write strobe
  input wire logic [7:0] reg_wdata,            // write data
  input wire logic       reg_rd,               // read strobe
  input wire logic [7:0] reg_rdata,            // read data
  input wire logic [1:0] pin_control,          // pin control
  input wire logic       pll_unlocked,         // loop unlocked
  input wire logic       int_out,              // pin level
  input wire logic       int_oe,               // pin enable
  input wire logic       buffer_window_select, // window
  input wire logic       cs_access_width,      // access mode
  input wire logic       subframe_select,      // subframe shown
  input wire logic       receiver_lock_method  // lock mode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [7:0] en_seen;
  // enable mask as last written by the host
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      en_seen <= 8'h00;
    end else if (reg_wr && reg_addr == 8'h21) begin
      en_seen <= reg_wdata;
    end
  end
  // a config write followed at once by a read of the same place
  sequence s_cfg_write;
    reg_wr && reg_addr inside {8'h21, 8'h22, 8'h23};
  endsequence
  sequence s_same_read;
    !reg_wr && reg_rd && reg_addr == $past(reg_addr);
  endsequence
  AST_CFG_READBACK: assert property (
    s_cfg_write ##1 s_same_read |=> reg_rdata == ($past(reg_wdata, 2) & 8'hBB))
    else $error("config readback wrong");
  AST_RDATA_HOLD: assert property (
    !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  AST_MASKED_ZERO: assert property (
    reg_rd && reg_addr == 8'h20 |=>
    (reg_rdata & ~($past(en_seen) & 8'hBB)) == 8'h00)
    else $error("masked flag read as one");
  AST_LOCK_FAULT: assert property (
    pll_unlocked [*3] ##0 (reg_rd && reg_addr == 8'h26) |=> reg_rdata[4])
    else $error("unlock not shown in fault register");
  AST_CTRL_WRITE: assert property (
    reg_wr && reg_addr == 8'h24 |=> {buffer_window_select, cs_access_width,
    subframe_select, receiver_lock_method} == {$past(reg_wdata[2:0]),
    $past(reg_wdata[6])}) else $error("control bits not written");
  AST_CTRL_RESET: assert property (
    $rose(resetn) |-> !buffer_window_select && !cs_access_width &&
    !subframe_select && receiver_lock_method) else $error("control reset wrong");
  AST_PIN_DRIVEN: assert property (
    (pin_control inside {2'b00, 2'b01}) [*2] |-> int_oe)
    else $error("push-pull pin not driven");
  AST_OPEN_DRAIN: assert property (
    (pin_control == 2'b10) [*2] |-> !int_out) else $error("open drain high");
  AST_PIN_OFF: assert property (
    (pin_control == 2'b11) [*2] |-> !int_oe) else $error("pin off driven");
endmodule
bind resu_event_status resu_event_status_monitor
  resu_event_status_monitor_inst (.*);

// ==== test/resu_host_model.sv ====
// host model driving the control port of the event status unit
`timescale 1ns/1ps
module resu_host_model (
  input  wire logic       clk_sys,   // device clock
  output logic      [7:0] reg_addr,  // address
  output logic            reg_wr,    // write strobe
  output logic      [7:0] reg_wdata, // write data
  output logic            reg_rd,    // read strobe
  input  wire logic [7:0] reg_rdata  // read data
);
  // port idle from time zero
  initial begin
    {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
  end
  // one request per edge; it stands until the next call
  task automatic put(input logic w, r, input logic [7:0] a, d);
    @(posedge clk_sys);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= d;
  endtask
  // read; the answer is taken once it has settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    put(1'b0, 1'b1, a, 8'h00);
    put(1'b0, 1'b0, a, 8'h00);
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
endmodule

// ==== test/resu_event_status_tb_top.sv ====
// self-checking bench for the receiver event status unit
`timescale 1ns/1ps
module resu_event_status_tb_top;
  logic       clk_sys = 1'b0;
  logic       resetn  = 1'b0;
  logic [1:0] pin_control = 2'b00;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v, ctrl_bits;
  logic [3:0] cs_aux_a, cs_aux_b, cs_bits_a, cs_bits_b;
  logic reg_wr, reg_rd, int_out, int_oe, rx_in_use, subframe_b;
  logic pll_unlocked, subcode_changed, cs_buffer_xfer, user_buffer_xfer;
  logic adc_overrange, subcode_boundary, subcode_crc_bad, cs_crc_bad;
  logic cs_block_boundary, subframe_boundary, rx_validity, rx_biphase_bad;
  logic rx_parity_bad, cs_general_a, cs_general_b;
  logic buffer_window_select, cs_access_width, subframe_select;
  logic receiver_lock_method;
  int   errors  = 0;
  int   n_tests = 0;
  assign ctrl_bits = {4'h0, buffer_window_select, cs_access_width,
                      subframe_select, receiver_lock_method};
  resu_event_status resu_event_status_inst (.*);
  resu_host_model resu_host_model_inst (.*);
  // 20 MHz clock
  always #25 clk_sys = ~clk_sys;
  // compare and count
  task automatic chk(input string nm, input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    resu_host_model_inst.put(1'b1, 1'b0, a, d);
    resu_host_model_inst.put(1'b0, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    resu_host_model_inst.rd(a, v);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, e);
    rd(a);
    chk(nm, v, e);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_sys);
  endtask
  // all three block boundaries at once
  task automatic bnd(input logic b);
    @(posedge clk_sys);
    {subcode_boundary, cs_block_boundary, subframe_boundary} <= 3'b111;
    subframe_b <= b;
    @(posedge clk_sys);
    {subcode_boundary, cs_block_boundary, subframe_boundary} <= 3'b000;
    settle;
  endtask
  task automatic xfer_pulse;
    @(posedge clk_sys);
    {subcode_changed, cs_buffer_xfer, user_buffer_xfer} <= 3'b111;
    @(posedge clk_sys);
    {subcode_changed, cs_buffer_xfer, user_buffer_xfer} <= 3'b000;
    settle;
  endtask
  // bounded wait for {int_out, int_oe}
  task automatic wpin(input logic [1:0] e);
    int i;
    @(negedge clk_sys);
    for (i = 0; i < 8 && {int_out, int_oe} !== e; i++) @(negedge clk_sys);
    chk("pin", {6'h00, int_out, int_oe}, {6'h00, e});
    if (i == 8) test_done;
  endtask
  task automatic pin_step(input logic [1:0] pc, input logic adc);
    @(posedge clk_sys);
    pin_control   <= pc;
    adc_overrange <= adc;
  endtask
  function automatic logic [7:0] exp_fault(input logic [5:0] f);
    return {1'b0, f[4], f[3], f[5], f[2], f[5] | f[1], f[1], f[0]};
  endfunction
  initial begin
    {pll_unlocked, subcode_changed, cs_buffer_xfer, user_buffer_xfer,
     adc_overrange, subcode_boundary, subcode_crc_bad, cs_block_boundary,
     cs_crc_bad, subframe_boundary, subframe_b, rx_validity,
     rx_biphase_bad, rx_parity_bad, cs_general_a, cs_general_b} = '0;
    {cs_aux_a, cs_bits_a, cs_aux_b, cs_bits_b} = 16'h0808;
    rx_in_use = 1'b1;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    @(negedge clk_sys);
    chk("ctrl rst", ctrl_bits, 8'h01);
    rc("buf rst", 8'h24, 8'h40);
    for (int a = 8'h21; a <= 8'h23; a++) begin
      rc("cfg rst", 8'(a), 8'h00);
      resu_host_model_inst.put(1'b1, 1'b0, 8'(a), 8'hFF);
      rc("cfg rw", 8'(a), 8'hBB);
    end
    wr(8'h24, 8'h47);
    rc("buf rw", 8'h24, 8'h47);
    chk("ctrl", ctrl_bits, 8'h0F);
    wr(8'h24, 8'h40);
    wr(8'h21, 8'h00);
    wr(8'h22, 8'h00);
    wr(8'h23, 8'h00);
    xfer_pulse;
    rc("masked", 8'h20, 8'h00);
    wr(8'h21, 8'hBB);
    xfer_pulse;
    rc("xfer", 8'h20, 8'h38);
    rc("cleared", 8'h20, 8'h00);
    @(posedge clk_sys);
    {pll_unlocked, adc_overrange} <= 2'b11;
    settle;
    rd(8'h20);
    chk("lock adc", v & 8'hFE, 8'h82);
    @(posedge clk_sys);
    {pll_unlocked, adc_overrange} <= 2'b00;
    settle;
    rd(8'h20);
    fork
      rc("same cycle", 8'h20, 8'h00);
      xfer_one: begin
        @(posedge clk_sys);
        cs_buffer_xfer <= 1'b1;
        @(posedge clk_sys);
        cs_buffer_xfer <= 1'b0;
      end
    join
    rc("kept", 8'h20, 8'h10);
    for (int i = 0; i < 64; i++) begin
      @(posedge clk_sys);
      {pll_unlocked, subcode_crc_bad, cs_crc_bad, rx_validity,
       rx_biphase_bad, rx_parity_bad} <= 6'(i);
      bnd(1'b0);
      rc("faults", 8'h26, exp_fault(6'(i)));
    end
    rd(8'h20);
    chk("fault flag", v & 8'h81, 8'h81);
    @(posedge clk_sys);
    {pll_unlocked, subcode_crc_bad, cs_crc_bad, rx_validity,
     rx_biphase_bad, rx_parity_bad} <= 6'h00;
    {cs_aux_a, cs_bits_a, cs_aux_b, cs_bits_b} <= 16'h8430;
    cs_general_b <= 1'b1;
    bnd(1'b0);
    rd(8'h20);
    rc("info a", 8'h25, 8'h84);
    wr(8'h24, 8'h41);
    bnd(1'b1);
    rc("info b", 8'h25, 8'h32);
    @(posedge clk_sys);
    cs_bits_b <= 4'h8;
    bnd(1'b1);
    rc("info pro", 8'h25, 8'h3B);
    @(posedge clk_sys);
    {rx_in_use, cs_bits_b} <= 5'h00;
    bnd(1'b1);
    rc("info unused", 8'h25, 8'h33);
    // pin: level mode on the adc source
    wr(8'h21, 8'h02);
    wr(8'h22, 8'h02);
    pin_step(2'b00, 1'b1);
    wpin(2'b11);
    pin_step(2'b01, 1'b1);
    wpin(2'b01);
    pin_step(2'b01, 1'b0);
    wpin(2'b11);
    pin_step(2'b10, 1'b0);
    wpin(2'b00);
    pin_step(2'b10, 1'b1);
    wpin(2'b01);
    pin_step(2'b11, 1'b0);
    settle;
    pin_step(2'b00, 1'b0);
    wpin(2'b01);
    // falling then rising edge modes
    wr(8'h22, 8'h00);
    wr(8'h23, 8'h02);
    rd(8'h20);
    pin_step(2'b00, 1'b1);
    settle;
    chk("fall idle", {6'h00, int_out, int_oe}, 8'h01);
    pin_step(2'b00, 1'b0);
    wpin(2'b11);
    rc("fall flag", 8'h20, 8'h02);
    wpin(2'b01);
    wr(8'h23, 8'h00);
    pin_step(2'b00, 1'b1);
    wpin(2'b11);
    test_done;
  end
endmodule
